// ### inc/asi_pkg.sv
// Constants, types and register map of the audio interrupt status block
package asi_pkg;

    localparam int ASI_DW = 32;
    localparam int ASI_AW = 8;
    localparam int ASI_RW = 8;
    localparam int ASI_N1 = 4;
    localparam int ASI_N2 = 6;
    localparam int ASI_NIRQ = 2;

    // Register indices; byte address is four times the index
    localparam logic [ASI_AW-1:0] ASI_IDX_STAT1 = 8'h07;
    localparam logic [ASI_AW-1:0] ASI_IDX_STAT2 = 8'h08;
    localparam logic [ASI_AW-1:0] ASI_IDX_MASK1 = 8'h09;
    localparam logic [ASI_AW-1:0] ASI_IDX_MODE1_MSB = 8'h0A;
    localparam logic [ASI_AW-1:0] ASI_IDX_MODE1_LSB = 8'h0B;
    localparam logic [ASI_AW-1:0] ASI_IDX_MASK2 = 8'h0C;
    localparam logic [ASI_AW-1:0] ASI_IDX_MODE2_MSB = 8'h0D;
    localparam logic [ASI_AW-1:0] ASI_IDX_MODE2_LSB = 8'h0E;
    localparam logic [ASI_AW-1:0] ASI_IDX_IRQ_STAT = 8'h20;
    localparam logic [ASI_AW-1:0] ASI_IDX_IRQ_CLR = 8'h21;
    localparam logic [ASI_AW-1:0] ASI_IDX_IRQ_EN = 8'h22;

    // Field positions
    localparam int ASI_B2_OVERFLOW = 5;
    localparam int ASI_B2_UNSETTLED = 4;
    localparam int ASI_B2_USER_DE = 3;
    localparam int ASI_B2_USER_EF = 2;
    localparam int ASI_B2_SUBCODE_Q = 1;
    localparam int ASI_B2_UBIT_OVW = 0;
    localparam int ASI_B1_RIGHT_OVR = 3;
    localparam int ASI_B1_CS_DE = 2;
    localparam int ASI_B1_CS_EF = 1;
    localparam int ASI_B1_RX_FAULT = 0;
    localparam int ASI_IRQ_B_GROUP1 = 0;
    localparam int ASI_IRQ_B_GROUP2 = 1;

    // Reset values
    localparam logic [ASI_RW-1:0] ASI_RST_STATUS = 8'h00;
    localparam logic [ASI_RW-1:0] ASI_RST_MASK = 8'h00;
    localparam logic [ASI_RW-1:0] ASI_RST_MODE = 8'h00;
    localparam logic [ASI_NIRQ-1:0] ASI_RST_IRQ = 2'h0;
    localparam logic [ASI_DW-1:0] ASI_RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        ASI_MODE_RISE = 2'b00,
        ASI_MODE_FALL = 2'b01,
        ASI_MODE_LEVEL = 2'b10,
        ASI_MODE_RSVD = 2'b11
    } asi_mode_t;

    typedef struct packed {
        logic rate_buffer_overflow;
        logic rate_tracking_unsettled;
        logic user_d_to_e_transfer;
        logic user_e_to_f_transfer;
        logic subcode_q_ready;
        logic user_bit_queue_overwrite;
    } asi_evt2_t;

    typedef struct packed {
        logic right_overrange;
        logic chanstat_d_to_e_transfer;
        logic chanstat_e_to_f_transfer;
        logic receiver_fault;
    } asi_evt1_t;

endpackage

// ### verilog/asi_flag_cell.sv
// One sticky interrupt flag with mask and mode selection
module asi_flag_cell
    import asi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cond,
    input wire logic mask,
    input wire asi_mode_t mode,
    input wire logic rd_clr,
    output logic flag_q,
    output logic pin_evt
);
    logic cond_prev_q;
    logic rise;
    logic fall;
    logic hit;
    logic flag_d;

    assign rise = cond & ~cond_prev_q;
    assign fall = ~cond & cond_prev_q;
    // Mode selects rising edge, falling edge or high level of the source as the event; reserved gives none
    assign hit = (mode == ASI_MODE_RISE) ? rise :
                 (mode == ASI_MODE_FALL) ? fall :
                 (mode == ASI_MODE_LEVEL) ? cond : 1'b0;
    // Masked events reach neither pin nor flag
    assign pin_evt = mask & hit;
    // Set wins over read clear; level source re-sets during the read
    // Masked flag is held at zero
    assign flag_d = mask & (hit | (flag_q & ~rd_clr));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cond_prev_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            cond_prev_q <= cond;
            flag_q <= flag_d;
        end
    end
endmodule

// ### verilog/asi_irq_sticky.sv
// Sticky interrupt summary with write-one clear, enable and level output
module asi_irq_sticky
    import asi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ASI_NIRQ-1:0] set,
    input wire logic clr_wr,
    input wire logic en_wr,
    input wire logic [ASI_NIRQ-1:0] wdata,
    output logic [ASI_NIRQ-1:0] stat_q,
    output logic [ASI_NIRQ-1:0] en_q,
    output logic irq
);
    logic [ASI_NIRQ-1:0] clr;
    logic [ASI_NIRQ-1:0] stat_d;
    logic [ASI_NIRQ-1:0] en_d;

    assign clr = clr_wr ? wdata : ASI_RST_IRQ;
    // Set wins over clear in the same cycle
    assign stat_d = set | (stat_q & ~clr);
    assign en_d = en_wr ? wdata : en_q;
    assign irq = |(stat_q & en_q);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stat_q <= ASI_RST_IRQ;
            en_q <= ASI_RST_IRQ;
        end else begin
            stat_q <= stat_d;
            en_q <= en_d;
        end
    end
endmodule

// ### verilog/asi_top.sv
// Interrupt status block with Avalon-MM register access
module asi_top
    import asi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ASI_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ASI_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [ASI_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire asi_evt1_t evt1,
    input wire asi_evt2_t evt2,
    output logic irq
);
    // Byte address of a register index
    function automatic logic [ASI_AW-1:0] addr_of(input logic [ASI_AW-1:0] idx);
        addr_of = {idx[ASI_AW-3:0], 2'b00};
    endfunction

    // Access hits a register
    function automatic logic hit_reg(input logic [ASI_AW-1:0] addr,
                                     input logic [ASI_AW-1:0] idx);
        hit_reg = (addr == addr_of(idx));
    endfunction

    // Bus handshake
    logic done_q;
    logic req;
    logic acc;
    logic rd_acc;
    logic wr_acc;
    logic wr_lane0;

    assign req = avs_read | avs_write;
    assign acc = req & ~done_q;
    assign rd_acc = acc & avs_read;
    assign wr_acc = acc & avs_write;
    assign wr_lane0 = wr_acc & avs_byteenable[0];
    assign avs_waitrequest = req & ~done_q;

    // Address decode
    logic sel_stat1;
    logic sel_stat2;
    logic sel_mask1;
    logic sel_mode1_msb;
    logic sel_mode1_lsb;
    logic sel_mask2;
    logic sel_mode2_msb;
    logic sel_mode2_lsb;
    logic sel_irq_stat;
    logic sel_irq_clr;
    logic sel_irq_en;

    assign sel_stat1 = hit_reg(avs_address, ASI_IDX_STAT1);
    assign sel_stat2 = hit_reg(avs_address, ASI_IDX_STAT2);
    assign sel_mask1 = hit_reg(avs_address, ASI_IDX_MASK1);
    assign sel_mode1_msb = hit_reg(avs_address, ASI_IDX_MODE1_MSB);
    assign sel_mode1_lsb = hit_reg(avs_address, ASI_IDX_MODE1_LSB);
    assign sel_mask2 = hit_reg(avs_address, ASI_IDX_MASK2);
    assign sel_mode2_msb = hit_reg(avs_address, ASI_IDX_MODE2_MSB);
    assign sel_mode2_lsb = hit_reg(avs_address, ASI_IDX_MODE2_LSB);
    assign sel_irq_stat = hit_reg(avs_address, ASI_IDX_IRQ_STAT);
    assign sel_irq_clr = hit_reg(avs_address, ASI_IDX_IRQ_CLR);
    assign sel_irq_en = hit_reg(avs_address, ASI_IDX_IRQ_EN);

    // Status reads clear as a side effect, once per access
    logic rd_clr1;
    logic rd_clr2;

    assign rd_clr1 = rd_acc & sel_stat1;
    assign rd_clr2 = rd_acc & sel_stat2;

    // Mask and mode registers
    logic [ASI_N1-1:0] mask1_q;
    logic [ASI_N1-1:0] mode1_msb_q;
    logic [ASI_N1-1:0] mode1_lsb_q;
    logic [ASI_N2-1:0] mask2_q;
    logic [ASI_N2-1:0] mode2_msb_q;
    logic [ASI_N2-1:0] mode2_lsb_q;
    logic [ASI_N1-1:0] mask1_d;
    logic [ASI_N1-1:0] mode1_msb_d;
    logic [ASI_N1-1:0] mode1_lsb_d;
    logic [ASI_N2-1:0] mask2_d;
    logic [ASI_N2-1:0] mode2_msb_d;
    logic [ASI_N2-1:0] mode2_lsb_d;

    assign mask1_d = (wr_lane0 & sel_mask1) ? avs_writedata[ASI_N1-1:0] : mask1_q;
    assign mode1_msb_d = (wr_lane0 & sel_mode1_msb) ? avs_writedata[ASI_N1-1:0] : mode1_msb_q;
    assign mode1_lsb_d = (wr_lane0 & sel_mode1_lsb) ? avs_writedata[ASI_N1-1:0] : mode1_lsb_q;
    assign mask2_d = (wr_lane0 & sel_mask2) ? avs_writedata[ASI_N2-1:0] : mask2_q;
    assign mode2_msb_d = (wr_lane0 & sel_mode2_msb) ? avs_writedata[ASI_N2-1:0] : mode2_msb_q;
    assign mode2_lsb_d = (wr_lane0 & sel_mode2_lsb) ? avs_writedata[ASI_N2-1:0] : mode2_lsb_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask1_q <= ASI_RST_MASK[ASI_N1-1:0];
            mode1_msb_q <= ASI_RST_MODE[ASI_N1-1:0];
            mode1_lsb_q <= ASI_RST_MODE[ASI_N1-1:0];
            mask2_q <= ASI_RST_MASK[ASI_N2-1:0];
            mode2_msb_q <= ASI_RST_MODE[ASI_N2-1:0];
            mode2_lsb_q <= ASI_RST_MODE[ASI_N2-1:0];
        end else begin
            mask1_q <= mask1_d;
            mode1_msb_q <= mode1_msb_d;
            mode1_lsb_q <= mode1_lsb_d;
            mask2_q <= mask2_d;
            mode2_msb_q <= mode2_msb_d;
            mode2_lsb_q <= mode2_lsb_d;
        end
    end

    // Event sources by bit position; overflow sits in bit 5
    logic [ASI_N1-1:0] src1;
    logic [ASI_N2-1:0] src2;

    assign src1 = evt1;
    assign src2 = evt2;

    // Flag cells
    logic [ASI_N1-1:0] flag1;
    logic [ASI_N2-1:0] flag2;
    logic [ASI_N1-1:0] pin1;
    logic [ASI_N2-1:0] pin2;

    for (genvar i = 0; i < ASI_N1; i++) begin : g_grp1
        asi_flag_cell u_cell (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .cond(src1[i]),
            .mask(mask1_q[i]),
            .mode(asi_mode_t'({mode1_msb_q[i], mode1_lsb_q[i]})),
            .rd_clr(rd_clr1),
            .flag_q(flag1[i]),
            .pin_evt(pin1[i])
        );
    end

    for (genvar i = 0; i < ASI_N2; i++) begin : g_grp2
        asi_flag_cell u_cell (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .cond(src2[i]),
            .mask(mask2_q[i]),
            .mode(asi_mode_t'({mode2_msb_q[i], mode2_lsb_q[i]})),
            .rd_clr(rd_clr2),
            .flag_q(flag2[i]),
            .pin_evt(pin2[i])
        );
    end

    // Interrupt summary: one sticky bit per group feeding the pin
    logic [ASI_NIRQ-1:0] irq_set;
    logic [ASI_NIRQ-1:0] irq_stat;
    logic [ASI_NIRQ-1:0] irq_en;

    assign irq_set = {|pin2, |pin1};

    asi_irq_sticky u_irq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(irq_set),
        .clr_wr(wr_lane0 & sel_irq_clr),
        .en_wr(wr_lane0 & sel_irq_en),
        .wdata(avs_writedata[ASI_NIRQ-1:0]),
        .stat_q(irq_stat),
        .en_q(irq_en),
        .irq(irq)
    );

    // Read data selection; upper bits of group 2 read zero
    logic [ASI_DW-1:0] rd_mux;

    assign rd_mux =
        sel_stat1 ? {{(ASI_DW-ASI_N1){1'b0}}, flag1} :
        sel_stat2 ? {{(ASI_DW-ASI_N2){1'b0}}, flag2} :
        sel_mask1 ? {{(ASI_DW-ASI_N1){1'b0}}, mask1_q} :
        sel_mode1_msb ? {{(ASI_DW-ASI_N1){1'b0}}, mode1_msb_q} :
        sel_mode1_lsb ? {{(ASI_DW-ASI_N1){1'b0}}, mode1_lsb_q} :
        sel_mask2 ? {{(ASI_DW-ASI_N2){1'b0}}, mask2_q} :
        sel_mode2_msb ? {{(ASI_DW-ASI_N2){1'b0}}, mode2_msb_q} :
        sel_mode2_lsb ? {{(ASI_DW-ASI_N2){1'b0}}, mode2_lsb_q} :
        sel_irq_stat ? {{(ASI_DW-ASI_NIRQ){1'b0}}, irq_stat} :
        sel_irq_en ? {{(ASI_DW-ASI_NIRQ){1'b0}}, irq_en} : ASI_RD_ZERO;

    // Read data captured in the cycle the access is taken
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            avs_readdata <= ASI_RD_ZERO;
        end else begin
            done_q <= acc;
            if (rd_acc) begin
                avs_readdata <= rd_mux;
            end
        end
    end
endmodule

// ### tb/asi_top_props.sv
// Assertion checker for the audio interrupt status block
module asi_top_props
    import asi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ASI_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ASI_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [ASI_DW-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire asi_evt1_t evt1,
    input wire asi_evt2_t evt2,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic [7:0] idx = {2'b00, avs_address[7:2]};
    wire logic wr_t = avs_write && avs_waitrequest && avs_byteenable[0];
    logic [5:0] msk_q;
    logic [5:0] mhi_q;
    logic [5:0] mlo_q;
    logic [1:0] en_q;
    // Shadow of the group-two mask and mode and of the interrupt enable
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            msk_q <= 6'h00;
            mhi_q <= 6'h00;
            mlo_q <= 6'h00;
            en_q <= 2'h0;
        end else if (wr_t) begin
            if (idx == ASI_IDX_MASK2) msk_q <= avs_writedata[5:0];
            if (idx == ASI_IDX_MODE2_MSB) mhi_q <= avs_writedata[5:0];
            if (idx == ASI_IDX_MODE2_LSB) mlo_q <= avs_writedata[5:0];
            if (idx == ASI_IDX_IRQ_EN) en_q <= avs_writedata[1:0];
        end
    end
    sequence s_take; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_rd2; avs_read && !avs_waitrequest && idx == ASI_IDX_STAT2; endsequence
    property p_rst; disable iff (1'b0) !rst_n |=> avs_readdata == ASI_RD_ZERO && !irq; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_ans; s_take |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("no answer one cycle after take");
    property p_hi; s_rd2 |-> avs_readdata[31:6] == 26'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper status bits not zero");
    property p_msk; s_rd2 |-> (avs_readdata[5:0] & ~msk_q) == 6'h00; endproperty
    a_msk: assert property (p_msk) else $error("masked flag reads one");
    property p_en0; en_q == 2'h0 |-> !irq; endproperty
    a_en0: assert property (p_en0) else $error("pin high with all enables off");
    property p_clr;
        wr_t && idx == ASI_IDX_IRQ_CLR && avs_writedata[1:0] == 2'h3 && evt1 == '0
            && evt2 == '0 && $past(evt1) == '0 && $past(evt2) == '0 |=> !irq;
    endproperty
    a_clr: assert property (p_clr) else $error("pin high after clear");
    property p_rise;
        evt2.rate_buffer_overflow && !$past(evt2.rate_buffer_overflow) && msk_q[5]
            && !mhi_q[5] && !mlo_q[5] && en_q[1] && !avs_write |=> irq;
    endproperty
    a_rise: assert property (p_rise) else $error("overflow rise missed");
    property p_lvl; |(evt2 & msk_q & mhi_q & ~mlo_q) && en_q[1] && !avs_write |=> irq; endproperty
    a_lvl: assert property (p_lvl) else $error("level source missed");
endmodule

// ### tb/asi_host.sv
// Host model: Avalon-MM master that also watches the interrupt pin
module asi_host
    import asi_pkg::*;
(
    input wire logic clk_sys,
    output logic [ASI_AW-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [ASI_DW-1:0] avs_writedata,
    input wire logic [ASI_DW-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    int irq_cycles = 0;
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    always @(posedge clk_sys) if (irq === 1'b1) irq_cycles++;
    // Request held until waitrequest is low at a rising edge
    task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address <= i << 2;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule

// ### tb/audio_src_interrupt_status_test.sv
// Self-checking testbench for the audio interrupt status block
module audio_src_interrupt_status_test
    import asi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic run = 1'b0;
    logic [ASI_AW-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic avs_waitrequest;
    logic irq;
    logic [ASI_DW-1:0] avs_writedata;
    logic [ASI_DW-1:0] avs_readdata;
    logic [ASI_DW-1:0] q;
    logic [ASI_DW-1:0] eq[$];
    asi_evt1_t evt1 = '0;
    asi_evt2_t evt2 = '0;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 68;
    logic [5:0] mk[2], mh[2], ml[2], fl[2], pv[2], cur, ev, m, h, l, i;
    logic [1:0] is_m, en_m, rc, st, clr;
    logic [7:0] ri[13] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
                           8'h20, 8'h21, 8'h22, 8'h05, 8'h3F};
    always #20 clk_sys = ~clk_sys;
    asi_top u_asi_top (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .evt1(evt1), .evt2(evt2), .irq(irq));
    asi_host u_asi_host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    always @(posedge clk_sys) begin
        evt1 <= run ? 4'($random(seed)) : 4'h0;
        evt2 <= run ? 6'($random(seed)) : 6'h00;
    end
    function automatic logic [31:0] rdv(input logic [5:0] x);
        case ({2'b00, x})
            ASI_IDX_STAT1: return {26'h0, fl[0]};
            ASI_IDX_STAT2: return {26'h0, fl[1]};
            ASI_IDX_MASK1: return {26'h0, mk[0]};
            ASI_IDX_MODE1_MSB: return {26'h0, mh[0]};
            ASI_IDX_MODE1_LSB: return {26'h0, ml[0]};
            ASI_IDX_MASK2: return {26'h0, mk[1]};
            ASI_IDX_MODE2_MSB: return {26'h0, mh[1]};
            ASI_IDX_MODE2_LSB: return {26'h0, ml[1]};
            ASI_IDX_IRQ_STAT: return {30'h0, is_m};
            ASI_IDX_IRQ_EN: return {30'h0, en_m};
            default: return 32'h0;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Reference model, stepped half a cycle ahead of each rising edge
    always @(negedge clk_sys) begin
        rc = 2'b00;
        clr = 2'b00;
        i = avs_address[7:2];
        if (!rst_n) begin
            foreach (mk[g]) begin
                mk[g] = '0;
                mh[g] = '0;
                ml[g] = '0;
                fl[g] = '0;
                pv[g] = '0;
            end
            is_m = '0;
            en_m = '0;
        end else begin
            chk("irq", {31'h0, |(is_m & en_m)}, {31'h0, irq});
            if (avs_read && avs_waitrequest) begin
                eq.push_back(rdv(i));
                rc = {i == 6'h08, i == 6'h07};
            end
            foreach (mk[g]) begin
                cur = g ? 6'(evt2) : 6'(evt1);
                ev = mk[g] & ((~mh[g] & ~ml[g] & cur & ~pv[g]) | (mh[g] & ~ml[g] & cur)
                    | (~mh[g] & ml[g] & ~cur & pv[g]));
                fl[g] = mk[g] & (ev | (fl[g] & ~{6{rc[g]}}));
                st[g] = |ev;
                pv[g] = cur;
            end
            if (avs_write && avs_waitrequest) begin
                case ({2'b00, i})
                    ASI_IDX_MASK1: mk[0] = avs_writedata[5:0];
                    ASI_IDX_MODE1_MSB: mh[0] = avs_writedata[5:0];
                    ASI_IDX_MODE1_LSB: ml[0] = avs_writedata[5:0];
                    ASI_IDX_MASK2: mk[1] = avs_writedata[5:0];
                    ASI_IDX_MODE2_MSB: mh[1] = avs_writedata[5:0];
                    ASI_IDX_MODE2_LSB: ml[1] = avs_writedata[5:0];
                    ASI_IDX_IRQ_CLR: clr = avs_writedata[1:0];
                    ASI_IDX_IRQ_EN: en_m = avs_writedata[1:0];
                    default: ;
                endcase
            end
            is_m = (is_m & ~clr) | st;
        end
    end
    task automatic rd(input logic [7:0] x);
        u_asi_host.xfer(1'b0, x, 32'h0, q);
        chk($sformatf("reg %h", x), eq.pop_front(), q);
    endtask
    task automatic wr(input logic [7:0] x, input logic [31:0] d);
        u_asi_host.xfer(1'b1, x, d, q);
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (ri[k]) rd(ri[k]);
        $display("reset values done");
        for (int p = 0; p < 8; p++) begin
            m = p < 2 ? 6'h3F : 6'($random(seed));
            h = p == 1 ? 6'h3F : p == 0 ? 6'h00 : 6'($random(seed));
            l = p < 2 ? 6'h00 : 6'($random(seed));
            wr(ASI_IDX_MASK1, {28'h0, m[3:0]});
            wr(ASI_IDX_MODE1_MSB, {28'h0, h[3:0]});
            wr(ASI_IDX_MODE1_LSB, {28'h0, l[3:0]});
            wr(ASI_IDX_MASK2, {26'h0, m});
            wr(ASI_IDX_MODE2_MSB, {26'h0, h});
            wr(ASI_IDX_MODE2_LSB, {26'h0, l});
            wr(ASI_IDX_IRQ_EN, p < 2 ? 32'h3 : 32'($random(seed) & 3));
            run <= 1'b1;
            repeat (40) begin
                rd(ri[($random(seed) & 255) % 13]);
                repeat ($random(seed) & 3) @(posedge clk_sys);
            end
            run <= 1'b0;
            repeat (3) @(posedge clk_sys);
            rd(ASI_IDX_STAT1);
            wr(ASI_IDX_STAT2, 32'hFF);
            rd(ASI_IDX_STAT2);
            wr(ASI_IDX_IRQ_CLR, 32'h3);
            rd(ASI_IDX_IRQ_STAT);
            $display("phase %0d done", p);
        end
        chk("irq seen", 32'h1, {31'h0, u_asi_host.irq_cycles > 0});
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (ri[k]) rd(ri[k]);
        $display("second reset done");
        results();
    end
endmodule
bind asi_top asi_top_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .evt1(evt1), .evt2(evt2), .irq(irq));
